// >>> logic/buck_seq_params.svh
// Timing counts, strap codes and widths for the dual buck sequencer
`ifndef BUCK_SEQ_PARAMS_SVH
`define BUCK_SEQ_PARAMS_SVH

`define CLK_FREQ_MHZ          100
`define SOFT_START_TIME_US    960
`define SOFT_START_CYCLES     (`SOFT_START_TIME_US * `CLK_FREQ_MHZ)
`define SWITCHOVER_DELAY_US   7700
`define SWITCHOVER_CYCLES     (`SWITCHOVER_DELAY_US * `CLK_FREQ_MHZ)
`define OSC_PERIOD_CYCLES     250
`define OSC_HALF_CYCLES       (`OSC_PERIOD_CYCLES / 2)
`define OSC_CNT_BITS          8
`define DELAY_CNT_BITS        20
`define SS_LEVEL_BITS         10
`define SS_LEVEL_STEPS        1024
`define SS_FULL_LEVEL         10'h3ff
`define SEL_GROUND            2'h0
`define SEL_TWO_VOLT_REF      2'h1
`define SEL_THREE_VOLT_RAIL   2'h2
`define SEL_FIVE_VOLT_RAIL    2'h3

`endif

// >>> logic/buck_seq_pkg.sv
// Types shared by the dual buck sequencer modules
`default_nettype none
`include "buck_seq_params.svh"
package buck_seq_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  typedef enum logic [1:0] {
    CH_OFF,
    CH_PREBIAS,
    CH_RUN
  } chan_state_t;

  typedef struct packed {
    chan_state_t                  st;
    logic                         hs;
    logic                         ls;
    logic [`DELAY_CNT_BITS-1:0]   step_cnt;
    logic [`SS_LEVEL_BITS-1:0]    ss_lvl;
  } chan_reg_t;

  typedef struct packed {
    logic                         strap_taken;
    logic                         ripple;
    logic                         ovp;
    logic                         ext_sel;
    logic                         any_on;
    logic                         rf_prev;
    logic [`OSC_CNT_BITS-1:0]     osc_cnt;
    logic                         ch1_tick;
    logic                         ch2_tick;
    logic [`DELAY_CNT_BITS-1:0]   sw_cnt;
    logic                         bypass;
    logic                         ref_on;
    logic                         ldo5_on;
  } top_reg_t;

endpackage
`default_nettype wire

// >>> logic/buck_channel.sv
// One switching channel: soft-start ramp, pre-bias wait and drive timing
`default_nettype none
`include "buck_seq_params.svh"
module buck_channel
  import buck_seq_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 94
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_sync_b,
  // Control
  input  wire logic                      run,
  input  wire logic                      period_start,
  input  wire logic                      off_trip,
  input  wire logic                      fb_above_ss,
  // Drive and ramp
  output logic                           high_drive,
  output logic                           low_drive,
  output logic [`SS_LEVEL_BITS-1:0]      ss_level,
  output logic                           running
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [`DELAY_CNT_BITS-1:0] STEP_LAST = `DELAY_CNT_BITS'(STEP_CYCLES - 1);

  chan_reg_t q;
  chan_reg_t d;

  always_comb begin
    d = q;
    case (q.st)
      CH_OFF: begin
        if (run) begin
          d.st       = CH_PREBIAS;
          d.step_cnt = '0;
          d.ss_lvl   = '0;
        end
      end
      CH_PREBIAS: begin
        // First pulse waits for feedback above the rising ramp
        if (!run) begin
          d.st = CH_OFF;
        end else if (period_start && fb_above_ss) begin // RQ5
          d.st = CH_RUN; // RQ6
        end
      end
      CH_RUN: begin
        if (!run) begin
          d.st = CH_OFF;
        end
      end
      default: begin
        d.st = CH_OFF;
      end
    endcase
    // Ramp keeps going across the pre-bias exit
    if (q.st != CH_OFF && run && q.ss_lvl != `SS_FULL_LEVEL) begin // RQ4
      if (q.step_cnt == STEP_LAST) begin
        d.step_cnt = '0;
        d.ss_lvl   = q.ss_lvl + `SS_LEVEL_BITS'(1);
      end else begin
        d.step_cnt = q.step_cnt + `DELAY_CNT_BITS'(1);
      end
    end
    if (d.st == CH_RUN) begin
      if (period_start) begin
        d.hs = 1'b1; // RQ11
      end else if (off_trip) begin
        d.hs = 1'b0; // RQ12
      end
    end else begin
      d.hs = 1'b0;
    end
    // Low side stays off before the first pulse so no negative current flows
    d.ls = (d.st == CH_RUN) && !d.hs; // RQ13
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      q <= '{st: CH_OFF, hs: 1'b0, ls: 1'b0, step_cnt: '0, ss_lvl: '0};
    end else begin
      q <= d;
    end
  end

  assign high_drive = q.hs;
  assign low_drive  = q.ls;
  assign ss_level   = q.ss_lvl;
  assign running    = (q.st == CH_RUN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);

  prebias_hold_a: assert property (q.st == CH_PREBIAS && !(period_start && fb_above_ss)
      |=> !high_drive && !low_drive) // RQ5
    else $error("drive active before first pulse allowed");
  hs_at_start_a: assert property (q.st == CH_RUN && run && period_start |=> q.hs) // RQ11
    else $error("high side not set at period start");
  hs_hold_off_a: assert property (!q.hs && !period_start |=> !q.hs) // RQ12
    else $error("high side came back inside the period");
  low_side_a: assert property (q.st == CH_RUN && run && off_trip && !period_start
      |=> !high_drive && low_drive) // RQ13
    else $error("low side missing while high side off");
  ramp_step_a: assert property (q.st != CH_OFF && run && q.ss_lvl != `SS_FULL_LEVEL
      && q.step_cnt == STEP_LAST |=> q.ss_lvl == $past(q.ss_lvl) + `SS_LEVEL_BITS'(1)) // RQ4
    else $error("soft-start ramp did not step");
  ramp_restart_a: assert property (q.st == CH_OFF && run |=> q.ss_lvl == '0) // RQ4
    else $error("soft-start did not restart from zero");

  prebias_exit_c: cover property (q.st == CH_PREBIAS ##1 q.st == CH_RUN);
  ramp_full_c: cover property (q.st == CH_RUN && q.ss_lvl == `SS_FULL_LEVEL);

endmodule // buck_channel
`default_nettype wire

// >>> logic/dual_buck_enable_and_pwm_timing.sv
// Enable decode, five-volt switchover, mode strap and two-phase timing
`default_nettype none
`include "buck_seq_params.svh"
// Summary of operation
// (RQ1) Main enable low: only three-volt rail on; reference, five-volt, channels off.
// (RQ2) Main enable high: reference and five-volt rail on, channels wait for requests.
// (RQ3) With main enable high each channel runs exactly while its own request is high.
// (RQ4) Channel request rise starts a soft-start ramp from zero to full over 0.96 ms.
// (RQ5) First high-side pulse waits until feedback exceeds the rising soft-start reference.
// (RQ6) After the pre-bias wait, start-up continues as from a discharged output.
// (RQ7) Channel 1 on, good, external five-volt above 4.8 V for 7.7 ms: bypass.
// (RQ8) External below 4.65 V, channel 1 off or bad: open bypass, regulator on.
// (RQ9) Peak-current or ripple control is chosen by the architecture strap.
// (RQ10) Strap levels: ground, reference, three-volt, five-volt give four mode/OVP pairs.
// (RQ11) Each period start turns on the high-side drive of a running channel.
// (RQ12) After the comparator clears the high side, it stays off until next period.
// (RQ13) Low-side drive is on whenever the high-side drive is off; the code keeps it off outside the run state.
// (RQ14) Ripple mode ends on-time when compensated sense equals the two-volt reference.
// (RQ15) Internal oscillator starts the two channel periods half a period apart.
// (RQ16) External clock: channel 1 on rising edge, channel 2 on falling edge.
// (RQ17) System applies the external clock before requests and omits the resistor.
// (RQ18) System never changes frequency source while a channel runs.
// (RQ19) Clock source latched at first request rise, held until both channels off.
module dual_buck_enable_and_pwm_timing
  import buck_seq_pkg::*;
#(
  parameter int unsigned SOFT_START_CYCLES = `SOFT_START_CYCLES,
  parameter int unsigned SWITCHOVER_CYCLES = `SWITCHOVER_CYCLES
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  // Enables and status
  input  wire logic                      main_power_on,
  input  wire logic                      channel1_run_request,
  input  wire logic                      channel2_run_request,
  input  wire logic                      channel1_output_good,
  // Five-volt switchover comparators
  input  wire logic                      ext5v_above_rise,
  input  wire logic                      ext5v_below_fall,
  // Strap and frequency source
  input  wire logic [1:0]                architecture_select_pin,
  input  wire logic                      ext_clock_mode,
  input  wire logic                      frequency_set_pin,
  // Loop comparators, bit 0 is channel 1
  input  wire logic [1:0]                current_comp_trip,
  input  wire logic [1:0]                ripple_comp_equal,
  input  wire logic [1:0]                feedback_above_ss,
  // Rail controls
  output logic                           three_volt_rail_en,
  output logic                           two_volt_reference_en,
  output logic                           five_volt_rail_en,
  output logic                           bypass_switch_close,
  output logic                           ripple_mode_select,
  output logic                           overvoltage_protect_en,
  // Channel drives, bit 0 is channel 1
  output logic [1:0]                     high_side_gate_drive,
  output logic [1:0]                     low_side_gate_drive,
  output logic [1:0]                     channel_running,
  output logic [`SS_LEVEL_BITS-1:0]      ch1_soft_start_level,
  output logic [`SS_LEVEL_BITS-1:0]      ch2_soft_start_level
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned SS_STEP_RAW = SOFT_START_CYCLES / `SS_LEVEL_STEPS;
  localparam int unsigned SS_STEP = (SS_STEP_RAW < 1) ? 1 : SS_STEP_RAW;
  localparam logic [`DELAY_CNT_BITS-1:0] SW_LAST = `DELAY_CNT_BITS'(SWITCHOVER_CYCLES - 1);
  localparam logic [`OSC_CNT_BITS-1:0] OSC_LAST = `OSC_CNT_BITS'(`OSC_PERIOD_CYCLES - 1);
  localparam logic [`OSC_CNT_BITS-1:0] OSC_HALF = `OSC_CNT_BITS'(`OSC_HALF_CYCLES);
  localparam int HALF_CYC = `OSC_HALF_CYCLES;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------
  top_reg_t   q;
  top_reg_t   d;
  logic [1:0] run;
  logic [1:0] off_trip;
  logic [1:0] period_start;
  logic       sw_drop;
  logic       sw_ready;
  logic       arch_bit0;
  logic       arch_bit1;

  assign arch_bit0 = architecture_select_pin[0];
  assign arch_bit1 = architecture_select_pin[1];
  // Requests are ignored entirely in shutdown
  assign run[0] = main_power_on && channel1_run_request; // RQ1 RQ3
  assign run[1] = main_power_on && channel2_run_request; // RQ3
  assign sw_ready = run[0] && channel1_output_good && ext5v_above_rise; // RQ7
  assign sw_drop  = !run[0] || !channel1_output_good || ext5v_below_fall; // RQ8
  assign period_start = {q.ch2_tick, q.ch1_tick};

  always_comb begin
    d = q;
    // Strap is caught once, on the first clock after reset release
    d.strap_taken = 1'b1;
    if (!q.strap_taken) begin // RQ9
      case (architecture_select_pin) // RQ10
        `SEL_GROUND: begin
          d.ripple = 1'b0;
          d.ovp    = 1'b1;
        end
        `SEL_TWO_VOLT_REF: begin
          d.ripple = 1'b1;
          d.ovp    = 1'b0;
        end
        `SEL_THREE_VOLT_RAIL: begin
          d.ripple = 1'b1;
          d.ovp    = 1'b1;
        end
        default: begin
          d.ripple = 1'b0;
          d.ovp    = 1'b0;
        end
      endcase
    end
    d.any_on = |run;
    // Source may only change while both channels are off
    if (!q.any_on && |run) begin
      d.ext_sel = ext_clock_mode; // RQ19 RQ18
    end
    d.rf_prev = frequency_set_pin;
    d.osc_cnt = (q.osc_cnt == OSC_LAST) ? '0 : q.osc_cnt + `OSC_CNT_BITS'(1);
    if (d.ext_sel) begin
      d.ch1_tick = frequency_set_pin && !q.rf_prev; // RQ16
      d.ch2_tick = !frequency_set_pin && q.rf_prev; // RQ16
    end else begin
      d.ch1_tick = (q.osc_cnt == '0); // RQ15
      d.ch2_tick = (q.osc_cnt == OSC_HALF); // RQ15
    end
    if (sw_drop) begin
      d.bypass = 1'b0; // RQ8
      d.sw_cnt = '0;
    end else if (!q.bypass && sw_ready) begin
      if (q.sw_cnt == SW_LAST) begin
        d.bypass = 1'b1; // RQ7
      end else begin
        d.sw_cnt = q.sw_cnt + `DELAY_CNT_BITS'(1);
      end
    end else if (!q.bypass) begin
      d.sw_cnt = '0;
    end
    d.ref_on  = main_power_on; // RQ1 RQ2
    d.ldo5_on = main_power_on && !d.bypass; // RQ2 RQ8
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [`SS_LEVEL_BITS-1:0] ss_lvl [2];

  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      // Control scheme picks which comparator ends the on-time
      assign off_trip[i] = q.ripple ? ripple_comp_equal[i] : current_comp_trip[i]; // RQ14
      buck_channel #(
        .STEP_CYCLES (SS_STEP)
      ) u_ch (
        .core_clk     (core_clk),
        .rst_sync_b   (rst_sync_b),
        .run          (run[i]),
        .period_start (period_start[i]),
        .off_trip     (off_trip[i]),
        .fb_above_ss  (feedback_above_ss[i]),
        .high_drive   (high_side_gate_drive[i]),
        .low_drive    (low_side_gate_drive[i]),
        .ss_level     (ss_lvl[i]),
        .running      (channel_running[i])
      );
    end
  endgenerate

  assign ch1_soft_start_level   = ss_lvl[0];
  assign ch2_soft_start_level   = ss_lvl[1];
  assign three_volt_rail_en     = 1'b1; // RQ1
  assign two_volt_reference_en  = q.ref_on;
  assign five_volt_rail_en      = q.ldo5_on;
  assign bypass_switch_close    = q.bypass;
  assign ripple_mode_select     = q.ripple;
  assign overvoltage_protect_en = q.ovp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);

  shutdown_rails_a: assert property (!main_power_on |=> !two_volt_reference_en
      && !five_volt_rail_en && !bypass_switch_close ##1 channel_running == 2'b00) // RQ1
    else $error("rails or channels on in shutdown");
  standby_rails_a: assert property (main_power_on && !q.bypass ##1 !q.bypass
      |-> two_volt_reference_en && five_volt_rail_en) // RQ2
    else $error("standby rails missing");
  request_gate_a: assert property (!channel2_run_request |=> ##1 !channel_running[1]) // RQ3
    else $error("channel 2 running without request");
  bypass_delay_a: assert property ($rose(q.bypass) |-> $past(q.sw_cnt) == SW_LAST) // RQ7
    else $error("bypass closed before full delay");
  bypass_drop_a: assert property (sw_drop |=> !bypass_switch_close
      && (five_volt_rail_en == $past(main_power_on))) // RQ8
    else $error("bypass not released at once");
  mode_decode_a: assert property (!q.strap_taken |=> ripple_mode_select ==
      ($past(arch_bit0) ^ $past(arch_bit1)) && overvoltage_protect_en == !$past(arch_bit0)) // RQ10
    else $error("strap decoded wrongly");
  clock_hold_a: assert property (q.any_on && |run |=> $stable(q.ext_sel)) // RQ19
    else $error("clock source changed while running");
  phase_split_a: assert property (!q.ext_sel && q.ch1_tick |-> ##HALF_CYC
      (q.ch2_tick || q.ext_sel)) // RQ15
    else $error("channel 2 not half a period after channel 1");
  ext_edges_a: assert property (q.ext_sel && q.any_on && |run && frequency_set_pin
      && !q.rf_prev |=> q.ch1_tick && !q.ch2_tick) // RQ16
    else $error("external rising edge did not start channel 1");

  bypass_close_c: cover property ($rose(q.bypass));
  both_run_c: cover property (channel_running == 2'b11);
  ext_sync_c: cover property (q.ext_sel && q.ch2_tick && channel_running[1]);

endmodule // dual_buck_enable_and_pwm_timing
`default_nettype wire

// >>> verif/buck_far_side.sv
// Far-side model: loop comparator stand-in and optional external clock source
`default_nettype none
module buck_far_side #(
  parameter int ON_CYCLES   = 30,
  parameter int HALF_CYCLES = 50
) (
  // Clock
  input  wire logic       core_clk,
  // Seen from the device and the system
  input  wire logic [1:0] high_drive,
  input  wire logic       clk_enable,
  // Answers to the device
  output logic      [1:0] comp_trip,
  output logic            ext_clock
);
  timeunit 1ns;
  timeprecision 1ps;

  int on_cnt [2];
  int half_cnt;

  initial begin
    comp_trip = 2'h0;
    ext_clock = 1'b0;
    half_cnt = 0;
    on_cnt = '{0, 0};
  end

  // Trip a fixed time after each turn-on; a slow loop would never trip at all
  always @(negedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      on_cnt[i] = high_drive[i] ? on_cnt[i] + 1 : 0;
      comp_trip[i] <= (on_cnt[i] >= ON_CYCLES);
    end
    // The clock stands still at 0 unless the system selects it
    if (clk_enable) begin
      half_cnt = half_cnt + 1;
      if (half_cnt == HALF_CYCLES) begin
        half_cnt = 0;
        ext_clock <= ~ext_clock;
      end
    end else begin
      half_cnt = 0;
      ext_clock <= 1'b0;
    end
  end
endmodule // buck_far_side
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the dual buck sequencer
`default_nettype none
`include "buck_seq_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SW_CYC = 20;
  logic                      core_clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic                      main_on = 1'b0;
  logic [1:0]                req = 2'h0;
  logic                      good = 1'b0;
  logic                      above = 1'b0;
  logic                      below = 1'b0;
  logic [1:0]                strap = 2'h0;
  logic                      ext_mode = 1'b0;
  logic                      ext_en = 1'b0;
  logic [1:0]                fb_ok = 2'h0;
  logic [1:0]                ripple_eq = 2'h0;
  wire logic [1:0]           trip;
  wire logic                 ext_clk;
  logic                      v3, ref_en, v5, byp, rip, ovp;
  logic [1:0]                hs, ls, run;
  logic [`SS_LEVEL_BITS-1:0] ss1, ss2;
  int                        miscompares = 0;
  int                        samples_checked = 0;
  int                        n, p;

  always #5 core_clk = ~core_clk;

  dual_buck_enable_and_pwm_timing #(
    .SOFT_START_CYCLES(1024),
    .SWITCHOVER_CYCLES(SW_CYC)
  ) u_dual_buck_enable_and_pwm_timing (
    .core_clk(core_clk), .rst_b(rst_b), .main_power_on(main_on),
    .channel1_run_request(req[0]), .channel2_run_request(req[1]),
    .channel1_output_good(good), .ext5v_above_rise(above), .ext5v_below_fall(below),
    .architecture_select_pin(strap), .ext_clock_mode(ext_mode),
    .frequency_set_pin(ext_clk), .current_comp_trip(trip), .ripple_comp_equal(ripple_eq),
    .feedback_above_ss(fb_ok), .three_volt_rail_en(v3), .two_volt_reference_en(ref_en),
    .five_volt_rail_en(v5), .bypass_switch_close(byp), .ripple_mode_select(rip),
    .overvoltage_protect_en(ovp), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .channel_running(run), .ch1_soft_start_level(ss1), .ch2_soft_start_level(ss2)
  );

  buck_far_side u_buck_far_side (
    .core_clk(core_clk), .high_drive(hs), .clk_enable(ext_en),
    .comp_trip(trip), .ext_clock(ext_clk)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // Select 0/1 is a high-side drive, 2 is the external clock
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    n = 0;
    while (((sel == 2) ? ext_clk : hs[sel[0]]) !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("MISMATCH wait %0d expected %b seen %b", sel, lvl, ~lvl);
        close_out();
      end
    end
  endtask

  // From a rise of a high-side drive to its next rise
  task automatic period_of(input int ch);
    // Line up on a rise first so the count spans one whole period
    wait_sig(ch, 1'b0, 300);
    wait_sig(ch, 1'b1, 300);
    wait_sig(ch, 1'b0, 300);
    chk("low side after trip", 16'h1, 16'(ls[ch[0]]));
    p = n;
    wait_sig(ch, 1'b1, 300);
    p = p + n;
  endtask

  task automatic do_reset(input logic [1:0] code);
    rst_b = 1'b0;
    main_on = 1'b0;
    req = 2'h0;
    strap = code;
    cycles(5);
    rst_b = 1'b1;
    cycles(4);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int c = 3; c >= 0; c--) begin
      do_reset(c[1:0]);
      chk("ripple select", 16'(c == 1 || c == 2), 16'(rip));
      chk("ovp enable", 16'(c == 0 || c == 2), 16'(ovp));
    end
    // Requests while main enable is low are ignored
    req = 2'h3;
    fb_ok = 2'h3;
    cycles(300);
    chk("three volt rail", 16'h1, 16'(v3));
    chk("shutdown outputs", 16'h0, 16'({ref_en, v5, run, hs, ls}));
    req = 2'h0;
    fb_ok = 2'h0;
    main_on = 1'b1;
    cycles(2);
    chk("standby rails", 16'h3, 16'({ref_en, v5}));
    chk("standby channels", 16'h0, 16'({run, hs}));
    // Channel 1 alone, held in pre-bias wait
    req = 2'h1;
    cycles(600);
    chk("pre-bias hold", 16'h0, 16'({run, hs, ls}));
    chk("ramp moving", 16'h1, 16'(ss1 > 0 && ss1 < 10'h3ff));
    fb_ok = 2'h1;
    wait_sig(0, 1'b1, 260);
    chk("only channel 1 runs", 16'h1, 16'(run));
    cycles(600);
    chk("ramp full", 16'h3ff, 16'(ss1));
    period_of(0);
    chk("internal period", 16'd250, 16'(p));
    // Second channel runs half a period behind
    req = 2'h3;
    fb_ok = 2'h3;
    wait_sig(1, 1'b1, 1500);
    wait_sig(0, 1'b1, 300);
    chk("phase offset", 16'd125, 16'(n));
    chk("ch2 ramp moving", 16'h1, 16'(ss2 > 0 && ss2 < 10'h3ff));
    // Switchover, then each way of dropping it
    for (int k = 0; k < 3; k++) begin
      good = 1'b1;
      above = 1'b1;
      below = 1'b0;
      req[0] = 1'b1;
      cycles(SW_CYC - 2);
      chk("bypass early", 16'h0, 16'(byp));
      cycles(5);
      chk("bypass closed", 16'h2, 16'({byp, v5}));
      above = 1'b0;
      cycles(3);
      chk("bypass held in band", 16'h2, 16'({byp, v5}));
      if (k == 0) begin
        below = 1'b1;
      end else if (k == 1) begin
        good = 1'b0;
      end else begin
        req[0] = 1'b0;
      end
      cycles(2);
      chk("bypass opened", 16'h1, 16'({byp, v5}));
    end
    // External clock, applied with everything off and kept while running
    req = 2'h0;
    cycles(10);
    ext_mode = 1'b1;
    ext_en = 1'b1;
    cycles(100);
    req = 2'h3;
    wait_sig(1, 1'b1, 400);
    wait_sig(2, 1'b0, 200);
    wait_sig(2, 1'b1, 200);
    wait_sig(0, 1'b1, 8);
    chk("rising edge start", 16'h1, 16'(n <= 4));
    period_of(0);
    chk("external period", 16'd100, 16'(p));
    wait_sig(2, 1'b0, 200);
    wait_sig(1, 1'b1, 8);
    chk("falling edge start", 16'h1, 16'(n <= 4));
    // Ripple strap: the current comparator is ignored, the ripple one ends the on-time
    do_reset(2'h1);
    main_on = 1'b1;
    req = 2'h1;
    wait_sig(0, 1'b1, 300);
    cycles(60);
    chk("ripple ignores current trip", 16'h1, 16'(hs[0]));
    ripple_eq = 2'h1;
    cycles(2);
    chk("ripple ends on-time", 16'h1, 16'({hs[0], ls[0]}));
    close_out();
  end
endmodule // tb
`default_nettype wire
